// >>> rtl/vdpc_pkg.sv
// Package with the constants, field layout and state types of the video pin control block.
package vdpc_pkg;

   // Core clock and the two data clock rates that the output clocks are derived from.
   localparam longint CLK_HZ     = 200_000_000;
   localparam longint RATE_LO_HZ = 27_000_000;
   localparam longint RATE_HI_HZ = 54_000_000;
   localparam int     NCO_W      = 16;
   localparam logic [NCO_W-1:0] INC_LO = NCO_W'((RATE_LO_HZ << NCO_W) / CLK_HZ);
   localparam logic [NCO_W-1:0] INC_HI = NCO_W'((RATE_HI_HZ << NCO_W) / CLK_HZ);

   // Layout of one buffered output word: the byte in the low bits, then the sideband flags.
   localparam int BYTE_W   = 8;
   localparam int WORD_W   = 16;
   localparam int F_HSYNC  = 8;
   localparam int F_VSYNC  = 9;
   localparam int F_ACTIVE = 10;
   localparam int F_ODD    = 11;
   localparam int F_NONINV = 12;
   localparam int F_HLOCK  = 13;
   localparam int F_VLOCK  = 14;
   localparam int F_SCALED = 15;

   // Restart count; the embedded controller is held in restart one cycle longer than this after a chip reset or core reset.
   localparam logic [3:0] RESTART_CYC = 4'h4;

   // Upper five bits of the serial-bus slave address; the two straps fill the low bits.
   localparam logic [6:0] BUS_ADDR_BASE = 7'h58;

   // Modes of the field sync pin.
   localparam logic [1:0] VS_MODE_VSYNC = 2'h0;
   localparam logic [1:0] VS_MODE_PHASE = 2'h1;
   localparam logic [1:0] VS_MODE_HLOCK = 2'h2;

   // Configuration values after reset.
   localparam logic       RST_DOUBLE   = 1'h0;
   localparam logic       RST_EMBEDDED = 1'h1;
   localparam logic [1:0] RST_VS_MODE  = 2'h0;
   localparam logic       RST_VLOCK    = 1'h0;
   localparam logic       RST_SVIDEO   = 1'h0;
   localparam logic       RST_IN_SEL   = 1'h0;

   typedef enum logic [1:0] {
      VDPC_RESTART,
      VDPC_RUN,
      VDPC_STANDBY
   } vdpc_pwr_e;

endpackage : vdpc_pkg

// >>> rtl/vdpc_buf2.sv
// Two-entry buffer with valid and ready on both sides; in_ready is registered, out_valid is decoded from the count.
`timescale 1ns/1ps
`default_nettype none

module vdpc_buf2 #(
   parameter int W = 16
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // Filling side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // Draining side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);

   logic [1:0]   cnt_r;
   logic [1:0]   cnt_nxt;
   logic [W-1:0] m0_r;
   logic [W-1:0] m0_nxt;
   logic [W-1:0] m1_r;
   logic [W-1:0] m1_nxt;
   logic         rdy_r;
   logic         rdy_nxt;
   logic         push;
   logic         pop;

   always_comb begin
      push    = in_valid && rdy_r;
      pop     = out_ready && (cnt_r != 2'h0);
      cnt_nxt = cnt_r;
      m0_nxt  = m0_r;
      m1_nxt  = m1_r;
      unique case ({push, pop})
         2'b10: begin
            if (cnt_r == 2'h0) begin
               m0_nxt = in_data;
            end else begin
               m1_nxt = in_data;
            end
            cnt_nxt = cnt_r + 2'h1;
         end
         2'b01: begin
            m0_nxt  = m1_r;
            cnt_nxt = cnt_r - 2'h1;
         end
         2'b11: begin
            if (cnt_r == 2'h1) begin
               m0_nxt = in_data;
            end else begin
               m0_nxt = m1_r;
               m1_nxt = in_data;
            end
         end
         2'b00: begin
         end
      endcase
      rdy_nxt = (cnt_nxt != 2'h2);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_r <= 2'h0;
         m0_r  <= '0;
         m1_r  <= '0;
         rdy_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         m0_r  <= m0_nxt;
         m1_r  <= m1_nxt;
         rdy_r <= rdy_nxt;
      end
   end

   assign in_ready  = rdy_r;
   assign out_valid = (cnt_r != 2'h0);
   assign out_data  = m0_r;

endmodule : vdpc_buf2

`default_nettype wire

// >>> rtl/vdpc_top.sv
// Pin control of one video decoder channel: power, reset, straps, output clocks and port.
`timescale 1ns/1ps
`default_nettype none

module vdpc_top (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Pins from the board
   input  wire logic       standby_n,
   input  wire logic       chip_reset_n,
   input  wire logic       bus_addr_strap0,
   input  wire logic       bus_addr_strap1,
   // Configuration write from the serial-bus host logic
   input  wire logic       cfg_wr,
   input  wire logic       cfg_double_rate,
   input  wire logic       cfg_embedded_sync,
   input  wire logic [1:0] cfg_vs_mode,
   input  wire logic       cfg_vlock_sel,
   input  wire logic       cfg_svideo,
   input  wire logic       cfg_input_sel,
   // Decoded pixel stream from the decoding pipeline
   input  wire logic       pix_valid,
   output logic            pix_ready,
   input  wire logic [7:0] pix_data,
   input  wire logic       pix_hsync,
   input  wire logic       pix_vsync,
   input  wire logic       pix_active,
   input  wire logic       pix_odd,
   input  wire logic       pix_noninv,
   input  wire logic       pix_hlock,
   input  wire logic       pix_vlock,
   input  wire logic       pix_scaled,
   // Channel output pins
   output logic            unscaled_clk_out,
   output logic            scaled_clk_out,
   output logic [7:0]      chan_video_bus,
   output logic            line_sync_out,
   output logic            field_sync_out,
   output logic            active_video_flag,
   output logic            field_parity_flag,
   // Device state
   output logic [6:0]      bus_slave_addr,
   output logic            in_standby,
   output logic            cpu_restart,
   output logic            svideo_mode,
   output logic            input_select
);

   // Two-stage synchronisers: bit 0 standby_n, 1 chip_reset_n, 3:2 straps.
   logic [3:0] meta_r;
   logic [3:0] sync_r;
   logic       stby_n_s;
   logic       crst_n_s;
   logic [1:0] strap_s;

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_r <= 4'h3;
         sync_r <= 4'h3;
      end else begin
         meta_r <= {bus_addr_strap1, bus_addr_strap0, chip_reset_n, standby_n};
         sync_r <= meta_r;
      end
   end

   assign stby_n_s = sync_r[0];
   assign crst_n_s = sync_r[1];
   assign strap_s  = sync_r[3:2];

   // Power and restart sequencing.
   vdpc_pkg::vdpc_pwr_e state_r;
   vdpc_pkg::vdpc_pwr_e state_nxt;
   logic [3:0]          rcnt_r;
   logic [3:0]          rcnt_nxt;
   logic [6:0]          addr_r;
   logic [6:0]          addr_nxt;
   // Registered decodes of the next state, so the state outputs come from flip-flops.
   logic                rst_st_r;
   logic                rst_st_nxt;
   logic                stby_st_r;
   logic                stby_st_nxt;

   always_comb begin
      state_nxt = state_r;
      rcnt_nxt  = rcnt_r;
      addr_nxt  = addr_r;
      unique case (state_r)
         vdpc_pkg::VDPC_RESTART: begin
            if (!crst_n_s) begin
               rcnt_nxt = vdpc_pkg::RESTART_CYC;
            end else if (rcnt_r != 4'h0) begin
               rcnt_nxt = rcnt_r - 4'h1;
            end else begin
               state_nxt = vdpc_pkg::VDPC_RUN;
               addr_nxt  = {vdpc_pkg::BUS_ADDR_BASE[6:2], strap_s};
            end
         end
         vdpc_pkg::VDPC_RUN: begin
            if (!stby_n_s) begin
               state_nxt = vdpc_pkg::VDPC_STANDBY;
            end else if (!crst_n_s) begin
               state_nxt = vdpc_pkg::VDPC_RESTART;
               rcnt_nxt  = vdpc_pkg::RESTART_CYC;
            end
         end
         vdpc_pkg::VDPC_STANDBY: begin
            // A chip reset seen here is not honoured.
            if (stby_n_s) begin
               state_nxt = vdpc_pkg::VDPC_RUN;
            end
         end
      endcase
      rst_st_nxt  = (state_nxt == vdpc_pkg::VDPC_RESTART);
      stby_st_nxt = (state_nxt == vdpc_pkg::VDPC_STANDBY);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_r   <= vdpc_pkg::VDPC_RESTART;
         rcnt_r    <= vdpc_pkg::RESTART_CYC;
         addr_r    <= vdpc_pkg::BUS_ADDR_BASE;
         rst_st_r  <= 1'b1;
         stby_st_r <= 1'b0;
      end else begin
         state_r   <= state_nxt;
         rcnt_r    <= rcnt_nxt;
         addr_r    <= addr_nxt;
         rst_st_r  <= rst_st_nxt;
         stby_st_r <= stby_st_nxt;
      end
   end

   // Configuration; only a restart returns it to defaults, standby leaves it alone.
   logic       double_r;
   logic       double_nxt;
   logic       embed_r;
   logic       embed_nxt;
   logic [1:0] vsm_r;
   logic [1:0] vsm_nxt;
   logic       vlk_r;
   logic       vlk_nxt;
   logic       svid_r;
   logic       svid_nxt;
   logic       isel_r;
   logic       isel_nxt;
   logic       restart;

   always_comb begin
      restart    = rst_st_r;
      double_nxt = double_r;
      embed_nxt  = embed_r;
      vsm_nxt    = vsm_r;
      vlk_nxt    = vlk_r;
      svid_nxt   = svid_r;
      isel_nxt   = isel_r;
      if (restart) begin
         double_nxt = vdpc_pkg::RST_DOUBLE;
         embed_nxt  = vdpc_pkg::RST_EMBEDDED;
         vsm_nxt    = vdpc_pkg::RST_VS_MODE;
         vlk_nxt    = vdpc_pkg::RST_VLOCK;
         svid_nxt   = vdpc_pkg::RST_SVIDEO;
         isel_nxt   = vdpc_pkg::RST_IN_SEL;
      end else if (cfg_wr) begin
         double_nxt = cfg_double_rate;
         embed_nxt  = cfg_embedded_sync;
         vsm_nxt    = cfg_vs_mode;
         vlk_nxt    = cfg_vlock_sel;
         svid_nxt   = cfg_svideo;
         isel_nxt   = cfg_input_sel;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         double_r <= vdpc_pkg::RST_DOUBLE;
         embed_r  <= vdpc_pkg::RST_EMBEDDED;
         vsm_r    <= vdpc_pkg::RST_VS_MODE;
         vlk_r    <= vdpc_pkg::RST_VLOCK;
         svid_r   <= vdpc_pkg::RST_SVIDEO;
         isel_r   <= vdpc_pkg::RST_IN_SEL;
      end else begin
         double_r <= double_nxt;
         embed_r  <= embed_nxt;
         vsm_r    <= vsm_nxt;
         vlk_r    <= vlk_nxt;
         svid_r   <= svid_nxt;
         isel_r   <= isel_nxt;
      end
   end

   // Buffer between the pipeline and the port; it drains one word per data clock.
   logic [vdpc_pkg::WORD_W-1:0] buf_in;
   logic [vdpc_pkg::WORD_W-1:0] buf_out;
   logic                        buf_valid;
   logic                        pop;

   assign buf_in = {pix_scaled, pix_vlock, pix_hlock, pix_noninv,
                    pix_odd, pix_active, pix_vsync, pix_hsync, pix_data};

   vdpc_buf2 #(
      .W (vdpc_pkg::WORD_W)
   ) u_buf (
      .clk       (clk),
      .rst       (rst || restart),
      .in_valid  (pix_valid),
      .in_ready  (pix_ready),
      .in_data   (buf_in),
      .out_valid (buf_valid),
      .out_ready (pop),
      .out_data  (buf_out)
   );

   // Data clocks come from a phase accumulator on the reference-derived core clock.
   logic [vdpc_pkg::NCO_W-1:0] acc_r;
   logic [vdpc_pkg::NCO_W-1:0] acc_nxt;
   logic                       run;
   logic                       fall;
   logic                       uclk_nxt;
   logic                       sclk_r;
   logic                       sclk_nxt;
   logic [7:0]                 byte_r;
   logic [7:0]                 byte_nxt;
   logic                       hs_r;
   logic                       hs_nxt;
   logic                       vs_r;
   logic                       vs_nxt;
   logic                       act_r;
   logic                       act_nxt;
   logic                       fid_r;
   logic                       fid_nxt;
   logic                       uclk_r;

   always_comb begin
      run      = (state_r == vdpc_pkg::VDPC_RUN);
      acc_nxt  = '0;
      if (run) begin
         acc_nxt = acc_r + (double_r ? vdpc_pkg::INC_HI : vdpc_pkg::INC_LO);
      end
      uclk_nxt = acc_nxt[vdpc_pkg::NCO_W-1];
      fall     = uclk_r && !uclk_nxt;
      pop      = fall && run && buf_valid;
      sclk_nxt = sclk_r;
      if (!run) begin
         sclk_nxt = 1'b0;
      end else if (!double_r) begin
         sclk_nxt = uclk_nxt;
      end else if (fall) begin
         sclk_nxt = !sclk_r;
      end
      byte_nxt = byte_r;
      hs_nxt   = hs_r;
      vs_nxt   = vs_r;
      act_nxt  = act_r;
      fid_nxt  = fid_r;
      if (!run) begin
         byte_nxt = 8'h00;
         hs_nxt   = 1'b0;
         vs_nxt   = 1'b0;
         act_nxt  = 1'b0;
         fid_nxt  = 1'b0;
      end else if (fall && !buf_valid) begin
         act_nxt = 1'b0;
      end else if (pop) begin
         byte_nxt = buf_out[vdpc_pkg::BYTE_W-1:0];
         hs_nxt   = buf_out[vdpc_pkg::F_HSYNC] && !embed_r;
         act_nxt  = buf_out[vdpc_pkg::F_ACTIVE];
         fid_nxt  = vlk_r ? buf_out[vdpc_pkg::F_VLOCK] : buf_out[vdpc_pkg::F_ODD];
         unique case (vsm_r)
            vdpc_pkg::VS_MODE_PHASE: vs_nxt = buf_out[vdpc_pkg::F_NONINV];
            vdpc_pkg::VS_MODE_HLOCK: vs_nxt = buf_out[vdpc_pkg::F_HLOCK];
            vdpc_pkg::VS_MODE_VSYNC: vs_nxt = buf_out[vdpc_pkg::F_VSYNC] && !embed_r;
            default:                 vs_nxt = 1'b0;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         acc_r  <= '0;
         uclk_r <= 1'b0;
         sclk_r <= 1'b0;
         byte_r <= 8'h00;
         hs_r   <= 1'b0;
         vs_r   <= 1'b0;
         act_r  <= 1'b0;
         fid_r  <= 1'b0;
      end else begin
         acc_r  <= acc_nxt;
         uclk_r <= uclk_nxt;
         sclk_r <= sclk_nxt;
         byte_r <= byte_nxt;
         hs_r   <= hs_nxt;
         vs_r   <= vs_nxt;
         act_r  <= act_nxt;
         fid_r  <= fid_nxt;
      end
   end

   assign unscaled_clk_out  = uclk_r;
   assign scaled_clk_out    = sclk_r;
   assign chan_video_bus    = byte_r;
   assign line_sync_out     = hs_r;
   assign field_sync_out    = vs_r;
   assign active_video_flag = act_r;
   assign field_parity_flag = fid_r;
   assign bus_slave_addr    = addr_r;
   assign in_standby        = stby_st_r;
   assign cpu_restart       = rst_st_r;
   assign svideo_mode       = svid_r;
   assign input_select      = isel_r;

   AST_STBY_QUIET: assert property (@(posedge clk) disable iff (rst)
      (state_r == vdpc_pkg::VDPC_STANDBY) ##1 (state_r == vdpc_pkg::VDPC_STANDBY)
      |-> !unscaled_clk_out && !active_video_flag && chan_video_bus == 8'h00)
      else $error("standby does not silence the port");

   AST_CFG_KEPT: assert property (@(posedge clk) disable iff (rst)
      (state_r == vdpc_pkg::VDPC_STANDBY) && !cfg_wr
      |=> double_r == $past(double_r) && vsm_r == $past(vsm_r) && svid_r == $past(svid_r))
      else $error("configuration changed during standby");

   AST_RESTART_DFLT: assert property (@(posedge clk) disable iff (rst)
      $rose(cpu_restart) |=> double_r == vdpc_pkg::RST_DOUBLE
      && embed_r == vdpc_pkg::RST_EMBEDDED && cpu_restart)
      else $error("chip reset did not restore defaults");

   AST_STRAP_ADDR: assert property (@(posedge clk) disable iff (rst)
      $fell(cpu_restart) |-> bus_slave_addr[1:0] == $past(strap_s)
      && bus_slave_addr[6:2] == vdpc_pkg::BUS_ADDR_BASE[6:2])
      else $error("slave address does not follow the straps");

   AST_FAST_CLK: assert property (@(posedge clk) disable iff (rst)
      $rose(unscaled_clk_out) && double_r && run && !cfg_wr |-> ##[1:2] !unscaled_clk_out)
      else $error("doubled data clock high phase too long");

   AST_SCALED_CLK: assert property (@(posedge clk) disable iff (rst)
      $rose(scaled_clk_out) && double_r && run && !cfg_wr |-> ##[3:4] !scaled_clk_out)
      else $error("scaled data clock not at the lower rate");

   AST_PORT_EDGE: assert property (@(posedge clk) disable iff (rst)
      run && $past(run) && ($changed(chan_video_bus) || $changed(active_video_flag))
      |-> $fell(unscaled_clk_out))
      else $error("port changed away from the data clock falling edge");

   AST_ACTIVE_FLAG: assert property (@(posedge clk) disable iff (rst)
      pop |=> active_video_flag == $past(buf_out[vdpc_pkg::F_ACTIVE]))
      else $error("active video flag does not follow the stream");

   AST_PHASE_PIN: assert property (@(posedge clk) disable iff (rst)
      pop && vsm_r == vdpc_pkg::VS_MODE_PHASE
      |=> field_sync_out == $past(buf_out[vdpc_pkg::F_NONINV]))
      else $error("line phase indicator wrong");

   AST_PARITY_PIN: assert property (@(posedge clk) disable iff (rst)
      pop && !vlk_r |=> field_parity_flag == $past(buf_out[vdpc_pkg::F_ODD]))
      else $error("field parity flag wrong");

endmodule : vdpc_top

`default_nettype wire

// >>> sim/vdpc_sink.sv
// Downstream receiver model that captures one channel port on its data clock.
`timescale 1ns/1ps
`default_nettype none

module vdpc_sink (
   // Clock and ignore window
   input  wire logic       clk,
   input  wire logic       quiet,
   // Channel port
   input  wire logic       unscaled_clk_out,
   input  wire logic [7:0] chan_video_bus,
   input  wire logic       line_sync_out,
   input  wire logic       field_sync_out,
   input  wire logic       active_video_flag,
   input  wire logic       field_parity_flag
);
   logic [11:0] port_w;
   logic [11:0] prev_r;
   logic        uclk_r;
   logic [11:0] got_q[$];
   logic [7:0]  blank_byte;
   int          skew_cnt = 0;

   assign port_w = {field_parity_flag, active_video_flag, field_sync_out, line_sync_out,
                    chan_video_bus};

   // Words are taken mid-period, where the port has settled since the falling data clock.
   always @(posedge unscaled_clk_out) begin
      if (active_video_flag) got_q.push_back(port_w);
      else blank_byte = chan_video_bus;
   end

   // A port change without a falling data clock would break capture on a single edge.
   always @(negedge clk) begin
      if (!quiet && port_w != prev_r && !(uclk_r && !unscaled_clk_out)) skew_cnt++;
      prev_r = port_w;
      uclk_r = unscaled_clk_out;
   end
endmodule : vdpc_sink

`default_nettype wire

// >>> sim/vdpc_top_tb_top.sv
// Self-checking testbench of the video pin control block.
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
   $display("BAD %s expected %0h seen %0h", nm, e, g); end end

module vdpc_top_tb_top;
   logic       clk = 1'b0;
   logic       rst, standby_n, chip_reset_n, bus_addr_strap0, bus_addr_strap1;
   logic       cfg_wr, cfg_double_rate, cfg_embedded_sync, cfg_vlock_sel;
   logic       cfg_svideo, cfg_input_sel, pix_valid, pix_ready;
   logic [1:0] cfg_vs_mode;
   logic [7:0] pix_data, chan_video_bus;
   logic       pix_hsync, pix_vsync, pix_active, pix_odd, pix_noninv;
   logic       pix_hlock, pix_vlock, pix_scaled;
   logic       unscaled_clk_out, scaled_clk_out, line_sync_out, field_sync_out;
   logic       active_video_flag, field_parity_flag, in_standby, cpu_restart;
   logic       svideo_mode, input_select;
   logic [6:0] bus_slave_addr;
   logic [4:0] c_m;
   int         num_errors = 0;
   int         total_checks = 0;
   int         cyc = 0;
   localparam logic [4:0] MODES [5] = '{5'h08, 5'h13, 5'h04, 5'h16, 5'h01};

   always #2.5 clk = ~clk;

   vdpc_top vdpc_top_i (.clk(clk), .rst(rst), .standby_n(standby_n),
      .chip_reset_n(chip_reset_n), .bus_addr_strap0(bus_addr_strap0),
      .bus_addr_strap1(bus_addr_strap1), .cfg_wr(cfg_wr), .cfg_double_rate(cfg_double_rate),
      .cfg_embedded_sync(cfg_embedded_sync), .cfg_vs_mode(cfg_vs_mode),
      .cfg_vlock_sel(cfg_vlock_sel), .cfg_svideo(cfg_svideo), .cfg_input_sel(cfg_input_sel),
      .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_data(pix_data),
      .pix_hsync(pix_hsync), .pix_vsync(pix_vsync), .pix_active(pix_active),
      .pix_odd(pix_odd), .pix_noninv(pix_noninv), .pix_hlock(pix_hlock),
      .pix_vlock(pix_vlock), .pix_scaled(pix_scaled), .unscaled_clk_out(unscaled_clk_out),
      .scaled_clk_out(scaled_clk_out), .chan_video_bus(chan_video_bus),
      .line_sync_out(line_sync_out), .field_sync_out(field_sync_out),
      .active_video_flag(active_video_flag), .field_parity_flag(field_parity_flag),
      .bus_slave_addr(bus_slave_addr), .in_standby(in_standby), .cpu_restart(cpu_restart),
      .svideo_mode(svideo_mode), .input_select(input_select));

   vdpc_sink vdpc_sink_i (.clk(clk), .quiet(rst | in_standby | cpu_restart),
      .unscaled_clk_out(unscaled_clk_out), .chan_video_bus(chan_video_bus),
      .line_sync_out(line_sync_out), .field_sync_out(field_sync_out),
      .active_video_flag(active_video_flag), .field_parity_flag(field_parity_flag));

   task automatic give_verdict;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : give_verdict

   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         give_verdict();
      end
   end

   function automatic logic [11:0] exp_port(input logic [15:0] w);
      logic fs;
      case (c_m[2:1])
         2'h0: fs = w[vdpc_pkg::F_VSYNC] & ~c_m[3];
         2'h1: fs = w[vdpc_pkg::F_NONINV];
         2'h2: fs = w[vdpc_pkg::F_HLOCK];
         default: fs = 1'b0;
      endcase
      return {c_m[0] ? w[vdpc_pkg::F_VLOCK] : w[vdpc_pkg::F_ODD], w[vdpc_pkg::F_ACTIVE],
              fs, w[vdpc_pkg::F_HSYNC] & ~c_m[3], w[7:0]};
   endfunction : exp_port

   task automatic drive(input logic [15:0] w);
      {pix_scaled, pix_vlock, pix_hlock, pix_noninv, pix_odd, pix_active, pix_vsync,
       pix_hsync, pix_data} = w;
   endtask : drive

   task automatic set_cfg(input logic [4:0] m, input logic sv, input logic is);
      {cfg_double_rate, cfg_embedded_sync, cfg_vs_mode, cfg_vlock_sel} = m;
      {cfg_svideo, cfg_input_sel, cfg_wr} = {sv, is, 1'b1};
      c_m = m;
      @(negedge clk) cfg_wr = 1'b0;
      @(negedge clk);
      `CHK("svideo_mode", sv, svideo_mode)
      `CHK("input_select", is, input_select)
   endtask : set_cfg

   task automatic wait_run;
      for (int k = 0; k < 40 && cpu_restart !== 1'b0; k++) @(negedge clk);
   endtask : wait_run

   // Counts core cycles between two falling edges of one data clock.
   task automatic meas(input bit sel, output int p);
      logic prev, cur;
      bit   f;
      int   cnt;
      prev = sel ? scaled_clk_out : unscaled_clk_out;
      {f, cnt, p} = 0;
      for (int k = 0; k < 100; k++) begin
         @(negedge clk);
         cur = sel ? scaled_clk_out : unscaled_clk_out;
         cnt++;
         if (prev && !cur) begin
            if (f) break;
            {f, cnt} = {1'b1, 32'd0};
         end
         prev = cur;
      end
      p = cnt;
   endtask : meas

   task automatic stream_chk(input int n);
      logic [15:0] sent[$];
      logic [15:0] w;
      int          refused;
      refused = 0;
      vdpc_sink_i.got_q.delete();
      for (int i = 0; i < n; i++) begin
         w = {8'(i * 37) | 8'h04, 8'(8'hC0 + i)};
         sent.push_back(w);
         drive(w);
         pix_valid = 1'b1;
         while (pix_ready !== 1'b1 && refused < 100) begin
            refused++;
            @(negedge clk);
         end
         @(negedge clk);
      end
      pix_valid = 1'b0;
      for (int k = 0; k < 300 && vdpc_sink_i.got_q.size() < n; k++) @(negedge clk);
      `CHK("stall_seen", 1'b1, refused > 0)
      `CHK("word_count", n, vdpc_sink_i.got_q.size())
      for (int i = 0; i < n && i < vdpc_sink_i.got_q.size(); i++)
         `CHK("port_word", exp_port(sent[i]), vdpc_sink_i.got_q[i])
   endtask : stream_chk

   task automatic t_modes;
      int p;
      foreach (MODES[i]) begin
         set_cfg(MODES[i], 1'b0, 1'b1);
         repeat (20) @(negedge clk);
         meas(1'b0, p);
         `CHK("uclk_period", 1'b1, MODES[i][4] ? (p >= 3 && p <= 4) : (p >= 7 && p <= 8))
         meas(1'b1, p);
         `CHK("sclk_period", 1'b1, p >= 7 && p <= 8)
         stream_chk(6);
      end
      drive(16'h005A);
      pix_valid = 1'b1;
      for (int k = 0; k < 20 && pix_ready !== 1'b1; k++) @(negedge clk);
      @(negedge clk) pix_valid = 1'b0;
      repeat (30) @(negedge clk);
      `CHK("blank_byte", 8'h5A, vdpc_sink_i.blank_byte)
      `CHK("active_low", 1'b0, active_video_flag)
      `CHK("port_skew", 0, vdpc_sink_i.skew_cnt)
   endtask : t_modes

   task automatic t_standby;
      logic hi;
      set_cfg(5'h13, 1'b1, 1'b1);
      standby_n = 1'b0;
      for (int k = 0; k < 8 && in_standby !== 1'b1; k++) @(negedge clk);
      `CHK("in_standby", 1'b1, in_standby)
      hi = 1'b0;
      repeat (20) @(negedge clk) hi = hi | unscaled_clk_out | scaled_clk_out;
      `CHK("clocks_stopped", 1'b0, hi)
      `CHK("port_idle", 8'h00, chan_video_bus)
      standby_n = 1'b1;
      for (int k = 0; k < 8 && in_standby !== 1'b0; k++) @(negedge clk);
      `CHK("svideo_kept", 1'b1, svideo_mode)
      `CHK("insel_kept", 1'b1, input_select)
      stream_chk(4);
   endtask : t_standby

   task automatic t_chip_reset;
      {bus_addr_strap1, bus_addr_strap0} = 2'b01;
      chip_reset_n = 1'b0;
      for (int k = 0; k < 8 && cpu_restart !== 1'b1; k++) @(negedge clk);
      `CHK("cpu_restart", 1'b1, cpu_restart)
      repeat (3) @(negedge clk);
      chip_reset_n = 1'b1;
      wait_run();
      `CHK("restart_done", 1'b0, cpu_restart)
      `CHK("svideo_dflt", vdpc_pkg::RST_SVIDEO, svideo_mode)
      `CHK("insel_dflt", vdpc_pkg::RST_IN_SEL, input_select)
      `CHK("addr_01", {vdpc_pkg::BUS_ADDR_BASE[6:2], 2'b01}, bus_slave_addr)
      c_m = {vdpc_pkg::RST_DOUBLE, vdpc_pkg::RST_EMBEDDED, vdpc_pkg::RST_VS_MODE,
             vdpc_pkg::RST_VLOCK};
      stream_chk(4);
   endtask : t_chip_reset

   initial begin
      {rst, standby_n, chip_reset_n, bus_addr_strap1, bus_addr_strap0} = 5'b11110;
      {cfg_wr, cfg_double_rate, cfg_embedded_sync, cfg_vs_mode, cfg_vlock_sel} = 6'h00;
      {cfg_svideo, cfg_input_sel, pix_valid} = 3'h0;
      drive(16'h0000);
      c_m = 5'h08;
      repeat (8) @(negedge clk);
      rst = 1'b0;
      wait_run();
      `CHK("addr_10", {vdpc_pkg::BUS_ADDR_BASE[6:2], 2'b10}, bus_slave_addr)
      `CHK("svideo_rst", 1'b0, svideo_mode)
      t_modes();
      t_standby();
      t_chip_reset();
      give_verdict();
   end
endmodule : vdpc_top_tb_top

`default_nettype wire
